//--- logic/ptmc_block.sv
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
module ptmc_block
  import ptmc_pkg::*;
(
  // apb slave
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [ptmc_pkg::APB_AW-1:0]  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  // fabric pins
  input  wire logic [ptmc_pkg::NUM_LOCAL-1:0]  local_in,
  input  wire logic [ptmc_pkg::NUM_DEDCLK-1:0] dedicated_clk,
  input  wire logic [ptmc_pkg::NUM_GLOBAL-1:0] global_sig,
  input  wire logic                            device_clear_n,
  // cell outputs
  output logic      [ptmc_pkg::NUM_CELLS-1:0]  cell_out
);
  import ptmc_pkg::*;

  localparam int PIN_W = NUM_LOCAL + NUM_DEDCLK + NUM_GLOBAL + 1;

  // product term: at least one literal used, all used literals match
  function automatic logic pt_eval(input logic [NUM_LITERALS-1:0] lit,
                                   input logic [NUM_LITERALS-1:0] tmask,
                                   input logic [NUM_LITERALS-1:0] cmask);
    return (|(tmask | cmask)) & (&(~tmask | lit)) & (&(~cmask | ~lit));
  endfunction : pt_eval

  // pick one synchronised source level by kind and index
  function automatic logic pick_src(input logic [1:0]             kind,
                                    input logic [4:0]             idx,
                                    input logic [NUM_LOCAL-1:0]   loc,
                                    input logic [NUM_DEDCLK-1:0]  ded,
                                    input logic [NUM_GLOBAL-1:0]  glb);
    logic v;
    v = 1'b0;
    if (kind == SRC_DEDCLK) v = ded[idx[0]];
    else if (kind == SRC_GLOBAL) v = glb[idx[1:0]];
    else if (kind == SRC_LOCAL) v = loc[idx];
    return v;
  endfunction : pick_src

  // --- pin synchroniser: three stages, accepted when the last two agree
  logic [PIN_W-1:0] s1_reg, s2_reg, s3_reg, pin_reg;
  logic [PIN_W-1:0] s1_next, s2_next, s3_next, pin_next;

  always_comb begin
    s1_next  = {device_clear_n, global_sig, dedicated_clk, local_in};
    s2_next  = s1_reg;
    s3_next  = s2_reg;
    pin_next = (s2_reg == s3_reg) ? s3_reg : pin_reg; // ignores single-cycle glitches
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      pin_reg <= '0;
    end else begin
      s1_reg  <= s1_next;
      s2_reg  <= s2_next;
      s3_reg  <= s3_next;
      pin_reg <= pin_next;
    end
  end

  logic [NUM_LOCAL-1:0]  loc_s;
  logic [NUM_DEDCLK-1:0] ded_s;
  logic [NUM_GLOBAL-1:0] glb_s;
  logic                  devclr_n_s;
  assign {devclr_n_s, glb_s, ded_s, loc_s} = pin_reg;

  // --- configuration registers and apb answer
  logic [31:0] clk_ctrl_reg, clk_ctrl_next;
  logic [31:0] clr_ctrl_reg, clr_ctrl_next;
  logic [31:0] cell_cfg_reg [NUM_CELLS];
  logic [31:0] cell_cfg_next[NUM_CELLS];
  logic [31:0] pt_reg       [NUM_PT_WORDS];
  logic [31:0] pt_next      [NUM_PT_WORDS];
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;
  logic [NUM_CELLS-1:0] out_reg, out_next;
  logic        hit;
  logic [31:0] rd_val;

  // address decode, shared by read and write
  always_comb begin
    hit    = 1'b1;
    rd_val = 32'h0000_0000;
    if (paddr[1:0] != 2'h0) begin
      hit = 1'b0;
    end else if (paddr == ADDR_CLK_CTRL) begin
      rd_val = clk_ctrl_reg;
    end else if (paddr == ADDR_STATUS) begin
      rd_val = {16'h0000, out_reg};
    end else if (paddr == ADDR_INPUTS) begin
      rd_val = loc_s;
    end else if (paddr == ADDR_CLR_CTRL) begin
      rd_val = clr_ctrl_reg;
    end else if (paddr[11:6] == ADDR_CELL_CFG[11:6]) begin
      rd_val = cell_cfg_reg[paddr[5:2]];
    end else if (paddr[11:9] == ADDR_PT_BASE[11:9] && paddr[3:2] != 2'h3) begin
      rd_val = pt_reg[paddr[8:2]];
    end else begin
      hit = 1'b0;
    end
  end

  // one wait state, then the write lands on the edge that sees pready
  always_comb begin
    clk_ctrl_next = clk_ctrl_reg;
    clr_ctrl_next = clr_ctrl_reg;
    cell_cfg_next = cell_cfg_reg;
    pt_next       = pt_reg;
    prdata_next   = prdata_reg;
    pslverr_next  = pslverr_reg;
    pready_next   = 1'b0;
    if (psel && penable && !pready_reg) begin
      pready_next  = 1'b1;
      prdata_next  = pwrite ? 32'h0000_0000 : rd_val;
      pslverr_next = !hit;
    end
    if (psel && penable && pready_reg && pwrite && hit) begin
      if (paddr == ADDR_CLK_CTRL) clk_ctrl_next = pwdata;
      else if (paddr == ADDR_CLR_CTRL) clr_ctrl_next = pwdata;
      else if (paddr[11:6] == ADDR_CELL_CFG[11:6]) cell_cfg_next[paddr[5:2]] = pwdata;
      else if (paddr[11:9] == ADDR_PT_BASE[11:9]) pt_next[paddr[8:2]] = pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_ctrl_reg <= RST_CLK_CTRL;
      clr_ctrl_reg <= RST_CLR_CTRL;
      for (int i = 0; i < NUM_CELLS; i++) cell_cfg_reg[i] <= RST_CELL_CFG;
      for (int i = 0; i < NUM_PT_WORDS; i++) pt_reg[i] <= RST_PT_WORD;
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      clk_ctrl_reg <= clk_ctrl_next;
      clr_ctrl_reg <= clr_ctrl_next;
      cell_cfg_reg <= cell_cfg_next;
      pt_reg       <= pt_next;
      prdata_reg   <= prdata_next;
      pready_reg   <= pready_next;
      pslverr_reg  <= pslverr_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // --- block clocks: edge of the chosen source, gated by its paired enable
  logic [1:0] ck_lvl, ck_prev_reg, ck_prev_next, ck_tick, clr_lvl;
  logic       dev_clr;

  always_comb begin
    for (int k = 0; k < 2; k++) begin
      ck_lvl[k] = pick_src(clk_ctrl_reg[k*CK_FIELD_W+CK_SRC_LSB +: 2],
                           clk_ctrl_reg[k*CK_FIELD_W+CK_IDX_LSB +: 5],
                           loc_s, ded_s, glb_s);
      ck_tick[k] = (clk_ctrl_reg[k*CK_FIELD_W+CK_FALL_BIT] ?
                    (ck_prev_reg[k] & ~ck_lvl[k]) : (~ck_prev_reg[k] & ck_lvl[k]))
                   & loc_s[clk_ctrl_reg[CK_EN_LSB+k*CK_EN_W +: CK_EN_W]];
      clr_lvl[k] = pick_src(clr_ctrl_reg[k*CL_FIELD_W+CL_SRC_BIT] ? SRC_LOCAL : SRC_GLOBAL,
                            clr_ctrl_reg[k*CL_FIELD_W+CL_IDX_LSB +: 5],
                            loc_s, ded_s, glb_s)
                   ^ clr_ctrl_reg[k*CL_FIELD_W+CL_INV_BIT];
    end
    ck_prev_next = ck_lvl;
    dev_clr      = clr_ctrl_reg[DEVCLR_EN_BIT] & ~devclr_n_s;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_prev_reg <= 2'h0;
    end else begin
      ck_prev_reg <= ck_prev_next;
    end
  end

  // --- product terms, select matrix and expander chain
  logic [NUM_LITERALS-1:0] lits;
  logic [NUM_CELLS-1:0]    pt0, pt1, own_or, exp_out, sum, aux, lend, borrow, q;

  assign lits = {out_reg[NUM_FEEDBACK-1:0], loc_s};

  always_comb begin
    for (int m = 0; m < NUM_CELLS; m++) begin
      pt0[m] = pt_eval(lits,
                       {pt_reg[m*8+2][8:0],   pt_reg[m*8][31:0]},
                       {pt_reg[m*8+2][24:16], pt_reg[m*8+1][31:0]});
      pt1[m] = pt_eval(lits,
                       {pt_reg[m*8+6][8:0],   pt_reg[m*8+4][31:0]},
                       {pt_reg[m*8+6][24:16], pt_reg[m*8+5][31:0]})
               ^ cell_cfg_reg[m][CF_INV_BIT];
      lend[m]   = cell_cfg_reg[m][CF_LEND_BIT];
      borrow[m] = cell_cfg_reg[m][CF_BORROW_BIT];
    end
    // each lent set adds one OR stage of delay down the chain
    exp_out[NUM_CELLS-1] = lend[NUM_CELLS-1] & (pt0[NUM_CELLS-1] | pt1[NUM_CELLS-1]);
    for (int m = NUM_CELLS - 2; m >= 0; m--) begin
      exp_out[m] = lend[m] & (pt0[m] | pt1[m] | (borrow[m] & exp_out[m+1]));
    end
    for (int m = 0; m < NUM_CELLS; m++) begin
      // jk and sr use the second term alone as k or r
      own_or[m] = lend[m] ? 1'b0 :
                  (cell_cfg_reg[m][2:0] inside {PTMC_MODE_JK, PTMC_MODE_SR}) ?
                  pt0[m] : (pt0[m] | pt1[m]);
      aux[m]    = lend[m] ? 1'b0 : pt1[m];
      // a lending cell passes its borrowed chain on and keeps nothing itself
      sum[m]    = (own_or[m] | ((m < NUM_CELLS - 1 && !lend[m]) ?
                                borrow[m] & exp_out[(m+1) % NUM_CELLS] : 1'b0))
                  ^ cell_cfg_reg[m][CF_XOR_BIT];
    end
  end

  // --- cell registers
  for (genvar m = 0; m < NUM_CELLS; m++) begin : g_cell
    logic [1:0] csel;
    assign csel = cell_cfg_reg[m][CF_CLRSEL_LSB +: 2];
    ptmc_cell u_cell (
      .pclk    (pclk),
      .presetn (presetn),
      .dev_clr (dev_clr),
      .clr     ((csel == 2'h1 && clr_lvl[0]) || (csel == 2'h2 && clr_lvl[1])),
      .tick    (ck_tick[cell_cfg_reg[m][CF_CLKSEL_BIT]]),
      .mode    (ptmc_mode_t'(cell_cfg_reg[m][CF_MODE_LSB +: 3])),
      .sum     (sum[m]),
      .aux     (aux[m]),
      .q       (q[m])
    );
  end

  // outputs: register state, or the logic itself when bypassed
  always_comb begin
    for (int m = 0; m < NUM_CELLS; m++) begin
      if (dev_clr) out_next[m] = 1'b0;
      else if (cell_cfg_reg[m][2:0] >= 3'(PTMC_MODE_BYPASS)) out_next[m] = sum[m];
      else out_next[m] = q[m];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_reg <= '0;
    end else begin
      out_reg <= out_next;
    end
  end

  assign cell_out = out_reg;

  a_apb_wait_one: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready_reg) |=> pready_reg) else $error("apb answer late");

  a_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready_reg |=> !pready_reg) else $error("pready held too long");

  a_devclr_all: assert property (@(posedge pclk) disable iff (!presetn)
    dev_clr |=> out_reg == '0) else $error("device clear left outputs set");

  a_bypass_follows: assert property (@(posedge pclk) disable iff (!presetn)
    (!dev_clr && cell_cfg_reg[0][2:0] == 3'(PTMC_MODE_BYPASS)) |=> out_reg[0] == $past(sum[0]))
    else $error("bypassed cell did not follow logic");

  a_sync_accept: assert property (@(posedge pclk) disable iff (!presetn)
    (s2_reg == s3_reg) |=> pin_reg == $past(s3_reg))
    else $error("synchroniser missed an agreed level");

  a_sync_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (s2_reg != s3_reg) |=> $stable(pin_reg))
    else $error("synchroniser took a disputed level");

  a_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready_reg && !hit) |=> pslverr_reg)
    else $error("unmapped access answered without error");
endmodule : ptmc_block

//--- logic/ptmc_pkg.sv
package ptmc_pkg;
  // bus geometry
  localparam int          APB_AW        = 12;
  localparam int          NUM_CELLS     = 16;
  localparam int          NUM_LOCAL     = 32;
  localparam int          NUM_FEEDBACK  = 9;
  localparam int          NUM_GLOBAL    = 4;
  localparam int          NUM_DEDCLK    = 2;
  localparam int          NUM_LITERALS  = NUM_LOCAL + NUM_FEEDBACK;
  localparam int          NUM_PT        = 2 * NUM_CELLS;
  localparam int          PT_WORDS      = 3;
  localparam int          NUM_PT_WORDS  = NUM_PT * 4;
  // register byte addresses
  localparam logic [11:0] ADDR_CLK_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS   = 12'h004;
  localparam logic [11:0] ADDR_INPUTS   = 12'h008;
  localparam logic [11:0] ADDR_CLR_CTRL = 12'h00c;
  localparam logic [11:0] ADDR_CELL_CFG = 12'h100;
  localparam logic [11:0] ADDR_PT_BASE  = 12'h200;
  // clock control fields, two block clocks
  localparam int          CK_SRC_LSB    = 0;
  localparam int          CK_IDX_LSB    = 2;
  localparam int          CK_FALL_BIT   = 7;
  localparam int          CK_FIELD_W    = 8;
  localparam int          CK_EN_LSB     = 16;
  localparam int          CK_EN_W       = 5;
  localparam logic [1:0]  SRC_DEDCLK    = 2'h0;
  localparam logic [1:0]  SRC_GLOBAL    = 2'h1;
  localparam logic [1:0]  SRC_LOCAL     = 2'h2;
  // clear control fields, two block clears
  localparam int          CL_SRC_BIT    = 0;
  localparam int          CL_IDX_LSB    = 1;
  localparam int          CL_INV_BIT    = 6;
  localparam int          CL_FIELD_W    = 8;
  localparam int          DEVCLR_EN_BIT = 16;
  // per cell configuration fields
  localparam int          CF_MODE_LSB   = 0;
  localparam int          CF_CLKSEL_BIT = 3;
  localparam int          CF_CLRSEL_LSB = 4;
  localparam int          CF_INV_BIT    = 6;
  localparam int          CF_XOR_BIT    = 7;
  localparam int          CF_LEND_BIT   = 8;
  localparam int          CF_BORROW_BIT = 9;
  // reset values
  localparam logic [31:0] RST_CLK_CTRL  = 32'h0000_0000;
  localparam logic [31:0] RST_CLR_CTRL  = 32'h0000_0000;
  localparam logic [31:0] RST_CELL_CFG  = 32'h0000_0004;
  localparam logic [31:0] RST_PT_WORD   = 32'h0000_0000;
  // register behaviour of one cell
  typedef enum logic [2:0] {
    PTMC_MODE_D,
    PTMC_MODE_T,
    PTMC_MODE_JK,
    PTMC_MODE_SR,
    PTMC_MODE_BYPASS
  } ptmc_mode_t;
endpackage : ptmc_pkg

//--- logic/ptmc_cell.sv
`timescale 1ns/1ps
module ptmc_cell
  import ptmc_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control from the block
  input  wire logic       dev_clr,
  input  wire logic       clr,
  input  wire logic       tick,
  input  wire ptmc_mode_t mode,
  // logic inputs
  input  wire logic       sum,
  input  wire logic       aux,
  // register state
  output logic            q
);
  import ptmc_pkg::*;

  logic q_reg;
  logic q_next;

  assign q = q_reg;

  // device clear beats the selected clear, which beats the clock event
  always_comb begin
    q_next = q_reg;
    if (dev_clr) begin
      q_next = 1'b0;
    end else if (clr) begin
      q_next = 1'b0;
    end else if (tick) begin
      unique case (mode)
        PTMC_MODE_D:  q_next = sum;
        PTMC_MODE_T:  q_next = q_reg ^ sum;
        PTMC_MODE_JK: q_next = (sum & ~q_reg) | (~aux & q_reg);
        PTMC_MODE_SR: q_next = (sum | q_reg) & ~aux;
        default:      q_next = q_reg; // bypassed or illegal code holds
      endcase
    end
  end

  // the register itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_reg <= 1'b0;
    end else begin
      q_reg <= q_next;
    end
  end

  a_clear_forces_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (clr || dev_clr) |=> !q_reg) else $error("clear did not zero the cell");

  a_hold_no_tick: assert property (@(posedge pclk) disable iff (!presetn)
    (!tick && !clr && !dev_clr) |=> $stable(q_reg)) else $error("cell moved without a tick");

  a_d_capture: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && !clr && !dev_clr && mode == PTMC_MODE_D) |=> q_reg == $past(sum))
    else $error("d cell missed its input");

  a_t_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && !clr && !dev_clr && mode == PTMC_MODE_T && sum) |=> q_reg != $past(q_reg))
    else $error("t cell did not toggle");
endmodule : ptmc_cell

//--- test/ptmc_fabric_model.sv
`timescale 1ns/1ps
// surrounding logic cells: registers what the bench asks for and drives
// the block's fabric pins from flops, so every pin moves just after pclk
module ptmc_fabric_model
  import ptmc_pkg::*;
(
  // clock
  input  wire logic                  pclk,
  // requested pin levels
  input  wire logic [NUM_LOCAL-1:0]  want_local,
  input  wire logic [NUM_DEDCLK-1:0] want_ded,
  input  wire logic [NUM_GLOBAL-1:0] want_glb,
  input  wire logic                  want_clr_n,
  // fabric pins
  output logic      [NUM_LOCAL-1:0]  local_in,
  output logic      [NUM_DEDCLK-1:0] dedicated_clk,
  output logic      [NUM_GLOBAL-1:0] global_sig,
  output logic                       device_clear_n
);
  // plain fabric drivers, no reset: levels are defined from time zero
  initial begin
    local_in       = '0;
    dedicated_clk  = '0;
    global_sig     = '0;
    device_clear_n = 1'b1;
  end
  always @(posedge pclk) begin
    local_in       <= want_local;
    dedicated_clk  <= want_ded;
    global_sig     <= want_glb;
    device_clear_n <= want_clr_n;
  end
endmodule : ptmc_fabric_model

//--- test/ptmc_block_tb_top.sv
`timescale 1ns/1ps
module ptmc_block_tb_top;
  import ptmc_pkg::*;
  logic                  pclk    = 1'b0;
  logic                  presetn = 1'b0;
  logic                  psel, penable, pwrite;
  logic [APB_AW-1:0]     paddr;
  logic [31:0]           pwdata, prdata;
  logic                  pready, pslverr;
  logic [NUM_LOCAL-1:0]  fab_local, local_in;
  logic [NUM_DEDCLK-1:0] fab_ded, dedicated_clk;
  logic [NUM_GLOBAL-1:0] fab_glb, global_sig;
  logic                  fab_clr_n, device_clear_n;
  logic [NUM_CELLS-1:0]  cell_out;
  int                    failures = 0;
  int                    n_checks = 0;

  // 25 MHz
  always #20 pclk = ~pclk;

  ptmc_fabric_model fab (.pclk(pclk), .want_local(fab_local), .want_ded(fab_ded),
    .want_glb(fab_glb), .want_clr_n(fab_clr_n), .local_in(local_in),
    .dedicated_clk(dedicated_clk), .global_sig(global_sig), .device_clear_n(device_clear_n));
  ptmc_block dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .local_in(local_in), .dedicated_clk(dedicated_clk),
    .global_sig(global_sig), .device_clear_n(device_clear_n), .cell_out(cell_out));

  task automatic final_report();
    if (failures == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n   = 0;
    rd  = '0;
    err = 1'b1;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    while (n < 20) begin
      @(posedge pclk);
      n++;
      // values read here are those the slave drove just before this edge, not its updates at it
      if (pready === 1'b1) begin
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        n       = 100;
      end
    end
    if (n != 100) begin
      failures++;
      final_report();
    end
  endtask : apb

  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
    chk("write error", {31'h0, err}, 32'h0);
  endtask : wreg

  task automatic rreg(input logic [11:0] a, input logic [31:0] exp, input string what);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(what, rd, exp);
  endtask : rreg

  // wait out the input synchroniser and the output register
  task automatic settle();
    repeat (10) @(posedge pclk);
  endtask : settle

  task automatic pin(input int i, input logic v);
    fab_local[i] <= v;
    settle();
  endtask : pin

  // rising then falling edge on local line 1 (block clock 0)
  task automatic tick();
    pin(1, 1'b1);
    pin(1, 1'b0);
  endtask : tick

  // rising then falling edge on global line 2
  task automatic gtick();
    fab_glb[2] <= 1'b1;
    settle();
    fab_glb[2] <= 1'b0;
    settle();
  endtask : gtick

  task automatic t_reset_values();
    logic [31:0] rd;
    logic        err;
    rreg(ADDR_CLK_CTRL, RST_CLK_CTRL, "clk ctrl");
    rreg(ADDR_CLR_CTRL, RST_CLR_CTRL, "clr ctrl");
    rreg(ADDR_CELL_CFG + 12'h03c, RST_CELL_CFG, "cell15 cfg");
    rreg(ADDR_PT_BASE, RST_PT_WORD, "pt word");
    apb(1'b0, ADDR_PT_BASE + 12'h00c, 32'h0, rd, err);
    chk("unmapped error", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
  endtask : t_reset_values

  task automatic t_inputs();
    fab_local <= 32'h5a00_f0c0;
    settle();
    rreg(ADDR_INPUTS, 32'h5a00_f0c0, "inputs");
    fab_local <= '0;
    settle();
  endtask : t_inputs

  // cell0 follows line 0, cell1 is an inverted empty term, cell3 reads cell0 back
  task automatic t_bypass();
    wreg(ADDR_PT_BASE, 32'h1);
    wreg(ADDR_CELL_CFG + 12'h004, 32'h44);
    wreg(ADDR_PT_BASE + 12'h068, 32'h1);
    pin(0, 1'b1);
    chk("bypass high", {28'h0, cell_out[3:0]}, 32'hb);
    pin(0, 1'b0);
    chk("bypass low", {28'h0, cell_out[3:0]}, 32'h2);
  endtask : t_bypass

  // cell5 lends its term to cell4
  task automatic t_expander();
    wreg(ADDR_PT_BASE + 12'h0a0, 32'h20);
    wreg(ADDR_CELL_CFG + 12'h014, 32'h104);
    wreg(ADDR_CELL_CFG + 12'h010, 32'h204);
    pin(5, 1'b1);
    chk("expander", {30'h0, cell_out[5:4]}, 32'h1);
    pin(5, 1'b0);
    chk("expander low", {30'h0, cell_out[5:4]}, 32'h0);
  endtask : t_expander

  // cell2: data line 3, clock0 from line 1, enable line 2
  task automatic t_dreg();
    wreg(ADDR_CLK_CTRL, 32'h0002_0006);
    wreg(ADDR_PT_BASE + 12'h040, 32'h8);
    wreg(ADDR_CELL_CFG + 12'h008, 32'h0);
    pin(3, 1'b1);
    chk("d before tick", {31'h0, cell_out[2]}, 32'h0);
    pin(2, 1'b1);
    tick();
    chk("d capture", {31'h0, cell_out[2]}, 32'h1);
    pin(3, 1'b0);
    pin(2, 1'b0);
    tick();
    chk("d gated", {31'h0, cell_out[2]}, 32'h1);
    pin(2, 1'b1);
    tick();
    chk("d zero", {31'h0, cell_out[2]}, 32'h0);
    wreg(ADDR_CELL_CFG + 12'h008, 32'h1);
    pin(3, 1'b1);
    tick();
    chk("t toggle1", {31'h0, cell_out[2]}, 32'h1);
    tick();
    chk("t toggle2", {31'h0, cell_out[2]}, 32'h0);
  endtask : t_dreg

  // clear0 from line 4, then inverted
  task automatic t_clear();
    wreg(ADDR_CELL_CFG + 12'h008, 32'h10);
    wreg(ADDR_CLR_CTRL, 32'h09);
    tick();
    chk("clr idle", {31'h0, cell_out[2]}, 32'h1);
    pin(4, 1'b1);
    chk("clr on", {31'h0, cell_out[2]}, 32'h0);
    tick();
    chk("clr holds", {31'h0, cell_out[2]}, 32'h0);
    pin(4, 1'b0);
    tick();
    chk("clr off", {31'h0, cell_out[2]}, 32'h1);
    wreg(ADDR_CLR_CTRL, 32'h49);
    settle();
    chk("clr inverted", {31'h0, cell_out[2]}, 32'h0);
    wreg(ADDR_CLR_CTRL, 32'h09);
    tick();
  endtask : t_clear

  // cell6 on clock1: dedicated clock 0, falling edge, enable line 7
  task automatic t_fall_clock();
    wreg(ADDR_CLK_CTRL, 32'h00e0_8006);
    wreg(ADDR_PT_BASE + 12'h0c0, 32'h8);
    wreg(ADDR_CELL_CFG + 12'h018, 32'h8);
    pin(7, 1'b1);
    fab_ded <= 2'h1;
    settle();
    chk("rise ignored", {31'h0, cell_out[6]}, 32'h0);
    fab_ded <= 2'h0;
    settle();
    chk("fall capture", {31'h0, cell_out[6]}, 32'h1);
  endtask : t_fall_clock

  task automatic t_devclr();
    fab_clr_n <= 1'b0;
    settle();
    chk("devclr off", {31'h0, cell_out[2]}, 32'h1);
    fab_clr_n <= 1'b1;
    settle(); // a stale low pin would clear everything once enabled
    wreg(ADDR_CLR_CTRL, 32'h0001_0009);
    pin(0, 1'b1);
    fab_clr_n <= 1'b0;
    settle();
    chk("devclr all", {16'h0, cell_out}, 32'h0);
    fab_clr_n <= 1'b1;
    settle();
    chk("devclr gone", {31'h0, cell_out[0]}, 32'h1);
  endtask : t_devclr

  // cell8 on clock0 from global line 2: jk, then sr with clear1 from global line 3
  task automatic t_jk_sr();
    wreg(ADDR_CLK_CTRL, 32'h00e0_8009);
    wreg(ADDR_CLR_CTRL, 32'h0001_0609);
    wreg(ADDR_PT_BASE + 12'h100, 32'h100);
    wreg(ADDR_PT_BASE + 12'h110, 32'h200);
    wreg(ADDR_CELL_CFG + 12'h020, 32'h2);
    pin(8, 1'b1);
    gtick();
    chk("jk set", {31'h0, cell_out[8]}, 32'h1);
    pin(9, 1'b1);
    gtick();
    chk("jk toggle1", {31'h0, cell_out[8]}, 32'h0);
    gtick();
    chk("jk toggle2", {31'h0, cell_out[8]}, 32'h1);
    pin(8, 1'b0);
    gtick();
    chk("jk reset", {31'h0, cell_out[8]}, 32'h0);
    wreg(ADDR_CELL_CFG + 12'h020, 32'h23);
    pin(8, 1'b1);
    pin(9, 1'b0);
    gtick();
    chk("sr set", {31'h0, cell_out[8]}, 32'h1);
    pin(9, 1'b1);
    gtick();
    chk("sr both", {31'h0, cell_out[8]}, 32'h0);
    pin(9, 1'b0);
    gtick();
    chk("sr set again", {31'h0, cell_out[8]}, 32'h1);
    fab_glb[3] <= 1'b1;
    settle();
    chk("global clear", {31'h0, cell_out[8]}, 32'h0);
    fab_glb[3] <= 1'b0;
    settle();
  endtask : t_jk_sr

  // cell12 lends to cell11, which lends on to cell10: two chained sets
  task automatic t_chain();
    wreg(ADDR_PT_BASE + 12'h160, 32'h800);
    wreg(ADDR_PT_BASE + 12'h180, 32'h1000);
    wreg(ADDR_CELL_CFG + 12'h030, 32'h104);
    wreg(ADDR_CELL_CFG + 12'h02c, 32'h304);
    wreg(ADDR_CELL_CFG + 12'h028, 32'h204);
    pin(12, 1'b1);
    chk("chain far", {29'h0, cell_out[12:10]}, 32'h1);
    pin(12, 1'b0);
    pin(11, 1'b1);
    chk("chain near", {29'h0, cell_out[12:10]}, 32'h1);
    pin(11, 1'b0);
    chk("chain idle", {29'h0, cell_out[12:10]}, 32'h0);
  endtask : t_chain

  // hang guard
  initial begin
    repeat (100000) @(posedge pclk);
    failures++;
    final_report();
  end

  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    fab_local = '0; fab_ded = '0; fab_clr_n = 1'b1;
    fab_glb = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values();
    t_inputs();
    t_bypass();
    t_expander();
    t_dreg();
    t_clear();
    t_fall_clock();
    t_devclr();
    t_jk_sr();
    t_chain();
    final_report();
  end
endmodule : ptmc_block_tb_top
